/* File: bench/ccs_monitor.sv */
// concurrent checks on the calibration sequencer ports
module ccs_monitor #(
   parameter int OVCAL_CYCLES = 20
) (
   input wire logic       ref_clk,
   input wire logic       rst_b,
   input wire logic       cmdValid,
   input wire logic [3:0] cmdCode,
   input wire logic       argFlag,
   input wire logic       calInhibit,
   input wire logic       constantVoltageRegulation,
   input wire logic       calEnabled,
   input wire logic       busy,
   input wire logic       respValid,
   input wire logic [1:0] respData,
   input wire logic       errValid,
   input wire logic [3:0] errNum,
   input wire logic       vConstPending,
   input wire logic       iConstPending,
   input wire logic       discardPulse,
   input wire logic       commitPulse,
   input wire logic       ovTripStart,
   input wire logic       ovTripStore
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BUSY_MAX = OVCAL_CYCLES + 4;
   logic taken;
   logic isState;
   // a command only counts when the sequencer is not running a trip search
   assign taken = cmdValid && !busy;
   assign isState = cmdCode == ccs_pkg::CMD_STATE_SET || cmdCode == ccs_pkg::CMD_STATE_QUERY;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   off_refuse_a: assert property (taken && !calEnabled && !isState |=>
      errValid && errNum == ccs_pkg::ERR_NOT_ENABLED) else $error("refusal while off wrong");
   inhibit_err_a: assert property (taken && cmdCode == ccs_pkg::CMD_STATE_SET && argFlag
      && calInhibit |=> errValid && errNum == ccs_pkg::ERR_INHIBIT && !calEnabled)
      else $error("inhibit not honoured");
   enable_fail_a: assert property (taken && !calEnabled && cmdCode == ccs_pkg::CMD_STATE_SET
      && argFlag |=> errValid == !calEnabled) else $error("enable outcome mismatch");
   query_state_a: assert property (taken && cmdCode == ccs_pkg::CMD_STATE_QUERY |=>
      respValid && respData == {1'b0, calEnabled}) else $error("query answer wrong");
   discard_new_a: assert property ($fell(calEnabled) && $past(vConstPending || iConstPending)
      |-> discardPulse && !vConstPending && !iConstPending) else $error("no discard");
   pending_src_a: assert property ($rose(vConstPending) |->
      $past(cmdValid && cmdCode == ccs_pkg::CMD_VOUT_VALUE)) else $error("bad pending source");
   commit_copy_a: assert property (commitPulse |-> $past(vConstPending || iConstPending)
      && !vConstPending && !iConstPending) else $error("commit wrong");
   wrong_mode_a: assert property (taken && calEnabled && cmdCode == ccs_pkg::CMD_OVTRIP_CAL
      && !constantVoltageRegulation |=> errValid && errNum == ccs_pkg::ERR_REG_STATE
      && !ovTripStart) else $error("mode error missing");
   trip_start_a: assert property (taken && calEnabled && cmdCode == ccs_pkg::CMD_OVTRIP_CAL
      && constantVoltageRegulation |=> ovTripStart && busy) else $error("trip not started");
   busy_bound_a: assert property ($rose(busy) |-> ##[1:BUSY_MAX] !busy)
      else $error("trip search never ends");
   trip_store_a: assert property (ovTripStore |-> $past(busy) && !busy)
      else $error("store outside search end");
   cover property (commitPulse);
   cover property (discardPulse);
   cover property (ovTripStore);
endmodule // ccs_monitor

bind ccs_sequencer ccs_monitor #(.OVCAL_CYCLES(OVCAL_CYCLES)) u_ccs_monitor (.ref_clk, .rst_b,
   .cmdValid, .cmdCode, .argFlag, .calInhibit, .constantVoltageRegulation, .calEnabled, .busy,
   .respValid, .respData, .errValid, .errNum, .vConstPending, .iConstPending, .discardPulse,
   .commitPulse, .ovTripStart, .ovTripStore);

/* File: bench/ccs_trip_model.sv */
// behavioural model of the analog trip search that answers the sequencer
module ccs_trip_model (
   input  wire logic       ref_clk,
   input  wire logic       ovTripStart,
   input  wire logic [7:0] delayCycles,
   input  wire logic       resultBad,
   output logic            ovTripDone,
   output logic            ovTripBad
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle at time zero; done settles at the first edge, long before any start
   logic [7:0] cnt = 8'h00;
   logic       run = 1'b0;
   // search runs on its own, then one done pulse
   // a delay longer than the sequencer limit models a search that never ends
   always @(posedge ref_clk) begin
      ovTripDone <= 1'b0;
      if (ovTripStart) begin
         run <= 1'b1;
         cnt <= 8'h00;
      end else if (run) begin
         cnt <= cnt + 8'h01;
         if (cnt == delayCycles) begin
            run <= 1'b0;
            ovTripDone <= 1'b1;
         end
      end
   end
   // result only means something with done; otherwise it follows cnt[0], which toggles during a search
   assign ovTripBad = ovTripDone ? resultBad : cnt[0];
endmodule // ccs_trip_model

/* File: bench/testbench.sv */
// self-checking bench for the calibration command sequencer
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] MODEL = 16'h2A5C; // arbitrary model code
   localparam logic [3:0]  K_ERR = 4'h1, K_RESP = 4'h2, K_COMMIT = 4'h3, K_DISC = 4'h4;
   localparam logic [3:0]  K_STORE = 4'h5;
   logic ref_clk = 1'b0, rst_b = 1'b0, cmdValid = 1'b0, argFlag = 1'b0, argPresent = 1'b0;
   logic [3:0] cmdCode = 4'h0, errNum;
   logic [15:0] argValue = 16'h0000, rnd;
   logic calInhibit = 1'b0, constantVoltageRegulation = 1'b1, constantCurrentRegulation = 1'b0;
   logic readbackConstBad = 1'b0, programConstBad = 1'b0, ovTripDone, ovTripBad, resultBad = 1'b0;
   logic calEnabled, busy, respValid, errValid, vConstPending, iConstPending;
   logic discardPulse, commitPulse, ovTripStart, ovTripStore;
   logic [1:0] respData;
   logic [7:0] delayCycles = 8'h03;
   logic [7:0] expQ[$];
   int badCount = 0, nCompared = 0, cycles = 0;

   ccs_sequencer #(.OVCAL_CYCLES(20), .MODEL_CODE(MODEL), .HAS_IMON(1'b1)) u_ccs_sequencer (
      .ref_clk, .rst_b, .cmdValid, .cmdCode, .argFlag, .argPresent, .argValue, .calInhibit,
      .constantVoltageRegulation, .constantCurrentRegulation, .readbackConstBad,
      .programConstBad, .ovTripDone, .ovTripBad, .calEnabled, .busy, .respValid, .respData,
      .errValid, .errNum, .vConstPending, .iConstPending, .discardPulse, .commitPulse,
      .ovTripStart, .ovTripStore);
   ccs_trip_model u_ccs_trip_model (.ref_clk, .ovTripStart, .delayCycles, .resultBad,
      .ovTripDone, .ovTripBad);

   // ----------------------------------------
   // clock, timeout and shared tasks
   // ----------------------------------------
   initial forever #25 ref_clk = ~ref_clk;
   // a hang is cut short well past the expected few hundred cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         badCount++;
         tally_and_finish();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      nCompared++;
      if (seen !== exp) begin
         badCount++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one command per strobe, launched just after an edge; note its answer if one is due
   task automatic send(input logic [3:0] c, input logic f, input logic p, input logic [15:0] v,
                       input logic [7:0] e, input bit x);
      cmdCode <= c;
      argFlag <= f;
      argPresent <= p;
      argValue <= v;
      cmdValid <= 1'b1;
      if (x) expQ.push_back(e);
      @(posedge ref_clk);
      cmdValid <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 60 && busy !== 1'b0; i++) @(posedge ref_clk);
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic take(input logic [7:0] seen);
      if (expQ.size() == 0) check(seen, 8'hFF);
      else check(seen, expQ.pop_front());
   endtask
   // ----------------------------------------
   // scoreboard: every answer takes the oldest note
   // ----------------------------------------
   always @(posedge ref_clk) begin
      if (errValid === 1'b1) take({K_ERR, errNum});
      if (respValid === 1'b1) take({K_RESP, 2'h0, respData});
      if (commitPulse === 1'b1) take({K_COMMIT, 4'h0});
      if (discardPulse === 1'b1) take({K_DISC, 4'h0});
      if (ovTripStore === 1'b1) take({K_STORE, 4'h0});
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'hEB910CF1));
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge ref_clk);
      for (int c = 2; c < 10; c++) send(4'(c), 1'b0, 1'b0, 16'h0000, {K_ERR, 4'h3}, 1);
      send(ccs_pkg::CMD_STATE_QUERY, 1'b0, 1'b0, 16'h0000, {K_RESP, 4'h0}, 1);
      $display("test 1 done");
      calInhibit <= 1'b1;
      send(ccs_pkg::CMD_STATE_SET, 1'b1, 1'b1, MODEL, {K_ERR, 4'h1}, 1);
      calInhibit <= 1'b0;
      send(ccs_pkg::CMD_STATE_SET, 1'b1, 1'b0, 16'h0000, {K_ERR, 4'h2}, 1);
      rnd = 16'($urandom());
      if (rnd == MODEL) rnd = ~rnd;
      send(ccs_pkg::CMD_STATE_SET, 1'b1, 1'b1, rnd, {K_ERR, 4'h2}, 1);
      check({7'h00, calEnabled}, 8'h00);
      send(ccs_pkg::CMD_STATE_SET, 1'b1, 1'b1, MODEL, 8'h00, 0);
      send(ccs_pkg::CMD_STATE_QUERY, 1'b0, 1'b0, 16'h0000, {K_RESP, 4'h1}, 1);
      $display("test 2 done");
      send(ccs_pkg::CMD_VOUT_POINT_SEL, 1'b1, 1'b0, 16'h0000, {K_ERR, 4'h6}, 1);
      send(ccs_pkg::CMD_VOUT_VALUE, 1'b0, 1'b0, 16'h0000, {K_ERR, 4'h6}, 1);
      // an undefined code while enabled is a sequence fault too
      send(4'hA, 1'b0, 1'b0, 16'h0000, {K_ERR, 4'h6}, 1);
      for (int k = 0; k < 4; k++) send(k[0] ? ccs_pkg::CMD_VOUT_VALUE :
         ccs_pkg::CMD_VOUT_POINT_SEL, k[1], 1'b0, 16'h0000, 8'h00, 0);
      check({7'h00, vConstPending}, 8'h01);
      send(ccs_pkg::CMD_SAVE, 1'b0, 1'b0, 16'h0000, {K_COMMIT, 4'h0}, 1);
      check({7'h00, vConstPending}, 8'h00);
      $display("test 3 done");
      send(ccs_pkg::CMD_IOUT_POINT_SEL, 1'b0, 1'b0, 16'h0000, {K_ERR, 4'h7}, 1);
      constantVoltageRegulation <= 1'b0;
      constantCurrentRegulation <= 1'b1;
      for (int r = 0; r < 3; r++) begin
         readbackConstBad <= (r == 0);
         programConstBad <= (r < 2);
         for (int k = 0; k < 4; k++) send(k[0] ? ccs_pkg::CMD_IOUT_VALUE :
            ccs_pkg::CMD_IOUT_POINT_SEL, k[1], 1'b0, 16'h0000, {K_ERR, 4'(4 + r)}, k == 3 && r < 2);
      end
      check({7'h00, iConstPending}, 8'h01);
      send(ccs_pkg::CMD_IMON_POINT_SEL, 1'b0, 1'b0, 16'h0000, 8'h00, 0);
      send(ccs_pkg::CMD_IOUT_VALUE, 1'b0, 1'b0, 16'h0000, 8'h00, 0);
      send(ccs_pkg::CMD_STATE_SET, 1'b0, 1'b0, 16'h0000, {K_DISC, 4'h0}, 1);
      check({6'h00, calEnabled, iConstPending}, 8'h00);
      $display("test 4 done");
      send(ccs_pkg::CMD_STATE_SET, 1'b1, 1'b1, MODEL, 8'h00, 0);
      send(ccs_pkg::CMD_PASSWORD, 1'b0, 1'b1, 16'h0000, 8'h00, 0);
      send(ccs_pkg::CMD_STATE_SET, 1'b0, 1'b0, 16'h0000, 8'h00, 0);
      send(ccs_pkg::CMD_STATE_SET, 1'b1, 1'b0, 16'h0000, 8'h00, 0);
      check({7'h00, calEnabled}, 8'h01);
      $display("test 5 done");
      send(ccs_pkg::CMD_OVTRIP_CAL, 1'b0, 1'b0, 16'h0000, {K_ERR, 4'h7}, 1);
      // voltage calibrated and output regulating in voltage mode first
      constantVoltageRegulation <= 1'b1;
      constantCurrentRegulation <= 1'b0;
      for (int t = 0; t < 3; t++) begin
         resultBad <= (t == 1);
         delayCycles <= (t == 2) ? 8'h1E : 8'h03;
         send(ccs_pkg::CMD_OVTRIP_CAL, 1'b0, 1'b0, 16'h0000,
              (t == 0) ? {K_STORE, 4'h0} : {K_ERR, 4'h5}, 1);
         // a query during the search is dropped without answer
         send(ccs_pkg::CMD_STATE_QUERY, 1'b0, 1'b0, 16'h0000, 8'h00, 0);
         // wait for the search before anything else
         wait_idle();
      end
      $display("test 6 done");
      check({4'h0, 4'(expQ.size())}, 8'h00);
      tally_and_finish();
   end
endmodule // testbench

/* File: common/ccs_pkg.sv */
// package of command codes, error numbers and timing constants for the calibration sequencer
package ccs_pkg;
   // ----------------------------------------
   // command codes presented on cmdCode
   // ----------------------------------------
   localparam logic [3:0] CMD_STATE_SET        = 4'h0; // enable / disable cal mode
   localparam logic [3:0] CMD_STATE_QUERY      = 4'h1;
   localparam logic [3:0] CMD_PASSWORD         = 4'h2;
   localparam logic [3:0] CMD_VOUT_POINT_SEL   = 4'h3; // vout_point_select_cmd
   localparam logic [3:0] CMD_VOUT_VALUE       = 4'h4;
   localparam logic [3:0] CMD_IOUT_POINT_SEL   = 4'h5; // iout_point_select_cmd
   localparam logic [3:0] CMD_IOUT_VALUE       = 4'h6; // iout_point_value_cmd
   localparam logic [3:0] CMD_IMON_POINT_SEL   = 4'h7; // imonitor_point_select_cmd
   localparam logic [3:0] CMD_OVTRIP_CAL       = 4'h8; // overvoltage_trip_cal_cmd
   localparam logic [3:0] CMD_SAVE             = 4'h9;

   // ----------------------------------------
   // error numbers reported on errNum
   // ----------------------------------------
   localparam logic [3:0] ERR_NONE        = 4'h0;
   localparam logic [3:0] ERR_INHIBIT     = 4'h1;
   localparam logic [3:0] ERR_PASSWORD    = 4'h2;
   localparam logic [3:0] ERR_NOT_ENABLED = 4'h3;
   localparam logic [3:0] ERR_READBACK    = 4'h4;
   localparam logic [3:0] ERR_PROGRAM     = 4'h5;
   localparam logic [3:0] ERR_SEQUENCE    = 4'h6;
   localparam logic [3:0] ERR_REG_STATE   = 4'h7;

   // ----------------------------------------
   // widths, reset values and timing
   // ----------------------------------------
   localparam int          PASS_W         = 16;
   localparam logic [15:0] PASS_DISABLED  = 16'h0000;
   localparam int          CLK_HZ         = 20_000_000;
   localparam int          OVCAL_MS       = 3000;  // several seconds of trip search
   localparam int          OVCAL_CYCLES   = (CLK_HZ / 1000) * OVCAL_MS;
   localparam logic [1:0]  RESP_CAL_OFF   = 2'h0;
   localparam logic [1:0]  RESP_CAL_ON    = 2'h1;

   // ----------------------------------------
   // point-sequence states
   // ----------------------------------------
   typedef enum {SEQ_IDLE, SEQ_LOW_SEL, SEQ_LOW_DONE, SEQ_HIGH_SEL,
                 SEQ_IMON_SEL} ccs_seq_t;
endpackage

/* File: rtl/ccs_nv_store.sv */
// nonvolatile-store shadow: password word and committed constants flags
module ccs_nv_store #(
   parameter int          PW = 16,
   parameter logic [15:0] PASS_FACTORY = 16'h1234  // arbitrary model code
) (
   input  wire logic          clk,
   input  wire logic          rstSync_b,
   input  wire logic          passWr,
   input  wire logic [PW-1:0] passIn,
   input  wire logic          constWr,
   input  wire logic [2:0]    constSel,
   output logic      [PW-1:0] passOut,
   output logic      [2:0]    constStored
);
   logic [PW-1:0] pass_r, pass_nxt;
   logic [2:0]    stored_r, stored_nxt;

   // next values: writes go straight into the shadow
   always_comb begin
      pass_nxt   = passWr ? passIn : pass_r;
      stored_nxt = constWr ? (stored_r | constSel) : stored_r;
   end

   // the factory password is a constant, so it is legal under async reset
   always_ff @(posedge clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         pass_r   <= PW'(PASS_FACTORY);
         stored_r <= 3'h0;
      end else begin
         pass_r   <= pass_nxt;
         stored_r <= stored_nxt;
      end
   end

   assign passOut     = pass_r;
   assign constStored = stored_r;
endmodule // ccs_nv_store

/* File: rtl/ccs_sequencer.sv */
// calibration command sequencer: mode, password, point order, commit, trip cal
module ccs_sequencer #(
   parameter int          OVCAL_CYCLES = ccs_pkg::OVCAL_CYCLES,
   parameter logic [15:0] MODEL_CODE   = 16'h1234,  // arbitrary model code
   parameter bit          HAS_IMON     = 1'b1
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic        cmdValid,
   input  wire logic [3:0]  cmdCode,
   input  wire logic        argFlag,      // state on, or high-end point
   input  wire logic        argPresent,   // password argument present
   input  wire logic [15:0] argValue,
   input  wire logic        calInhibit,   // hardware inhibit strap
   input  wire logic        constantVoltageRegulation,
   input  wire logic        constantCurrentRegulation,
   input  wire logic        readbackConstBad,
   input  wire logic        programConstBad,
   input  wire logic        ovTripDone,   // analog trip search finished
   input  wire logic        ovTripBad,
   output logic             calEnabled,
   output logic             busy,
   output logic             respValid,
   output logic [1:0]       respData,
   output logic             errValid,
   output logic [3:0]       errNum,
   output logic             vConstPending,
   output logic             iConstPending,
   output logic             discardPulse,
   output logic             commitPulse,
   output logic             ovTripStart,
   output logic             ovTripStore
);
   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic rstMeta_r, rstSync_b;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_r <= 1'b0;
         rstSync_b <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_b <= rstMeta_r;
      end
   end

   // ----------------------------------------
   // state
   // ----------------------------------------
   localparam int CW = $clog2(OVCAL_CYCLES + 1);
   ccs_pkg::ccs_seq_t vSeq_r, vSeq_nxt, iSeq_r, iSeq_nxt;
   logic          cal_r, cal_nxt, busy_r, busy_nxt;
   logic [CW-1:0] ovCnt_r, ovCnt_nxt;
   logic          respV_r, respV_nxt, errV_r, errV_nxt;
   logic [1:0]    respD_r, respD_nxt;
   logic [3:0]    errN_r, errN_nxt;
   logic          vPend_r, vPend_nxt, iPend_r, iPend_nxt;
   logic          disc_r, disc_nxt, comm_r, comm_nxt;
   logic          ovStart_r, ovStart_nxt, ovStore_r, ovStore_nxt;
   logic          passWr, constWr;
   logic [2:0]    constSel;
   logic [15:0]   storedPass;

   ccs_nv_store #(
      .PW           (ccs_pkg::PASS_W),
      .PASS_FACTORY (MODEL_CODE)
   ) uNv (
      .clk         (ref_clk),
      .rstSync_b   (rstSync_b),
      .passWr      (passWr),
      .passIn      (argValue),
      .constWr     (constWr),
      .constSel    (constSel),
      .passOut     (storedPass),
      .constStored ()
   );

   // report an error (only one per command)
   function automatic void raiseErr(input  logic [3:0] n,
                                    output logic       v,
                                    output logic [3:0] e);
      v = 1'b1;
      e = n;
   endfunction

   // ----------------------------------------
   // command decode and next-state logic
   // ----------------------------------------
   always_comb begin
      cal_nxt     = cal_r;
      busy_nxt    = busy_r;
      ovCnt_nxt   = ovCnt_r;
      vSeq_nxt    = vSeq_r;
      iSeq_nxt    = iSeq_r;
      vPend_nxt   = vPend_r;
      iPend_nxt   = iPend_r;
      respV_nxt   = 1'b0;
      respD_nxt   = respD_r;
      errV_nxt    = 1'b0;
      errN_nxt    = errN_r;
      disc_nxt    = 1'b0;
      comm_nxt    = 1'b0;
      ovStart_nxt = 1'b0;
      ovStore_nxt = 1'b0;
      passWr      = 1'b0;
      constWr     = 1'b0;
      constSel    = 3'h0;

      // trip calibration runs on its own
      if (busy_r) begin
         if (ovTripDone || ovCnt_r == CW'(0)) begin
            busy_nxt = 1'b0;
            if (ovTripBad || !ovTripDone) begin
               raiseErr(ccs_pkg::ERR_PROGRAM, errV_nxt, errN_nxt);
            end else begin
               ovStore_nxt = 1'b1;
               constWr     = 1'b1;
               constSel    = 3'h4;
            end
         end else begin
            ovCnt_nxt = ovCnt_r - CW'(1);
         end
      end else if (cmdValid) begin
         if (cmdCode == ccs_pkg::CMD_STATE_QUERY) begin
            respV_nxt = 1'b1;
            respD_nxt = cal_r ? ccs_pkg::RESP_CAL_ON : ccs_pkg::RESP_CAL_OFF;
         end else if (cmdCode == ccs_pkg::CMD_STATE_SET) begin
            if (argFlag) begin
               if (calInhibit) begin
                  raiseErr(ccs_pkg::ERR_INHIBIT, errV_nxt, errN_nxt);
               end else if (storedPass == ccs_pkg::PASS_DISABLED ||
                            (argPresent && argValue == storedPass)) begin
                  cal_nxt = 1'b1;
               end else begin
                  raiseErr(ccs_pkg::ERR_PASSWORD, errV_nxt, errN_nxt);
               end
            end else if (cal_r) begin
               cal_nxt = 1'b0;
               disc_nxt = vPend_r | iPend_r;
               vPend_nxt = 1'b0;
               iPend_nxt = 1'b0;
               vSeq_nxt  = ccs_pkg::SEQ_IDLE;
               iSeq_nxt  = ccs_pkg::SEQ_IDLE;
            end
         end else if (!cal_r) begin
            raiseErr(ccs_pkg::ERR_NOT_ENABLED, errV_nxt, errN_nxt);
         end else begin
            unique case (cmdCode)
               ccs_pkg::CMD_PASSWORD: begin
                  passWr = 1'b1;
               end
               ccs_pkg::CMD_VOUT_POINT_SEL: begin
                  if (!constantVoltageRegulation) begin
                     raiseErr(ccs_pkg::ERR_REG_STATE, errV_nxt, errN_nxt);
                  end else if (!argFlag) begin
                     vSeq_nxt = ccs_pkg::SEQ_LOW_SEL;
                  end else if (vSeq_r == ccs_pkg::SEQ_LOW_DONE) begin
                     vSeq_nxt = ccs_pkg::SEQ_HIGH_SEL;
                  end else begin
                     raiseErr(ccs_pkg::ERR_SEQUENCE, errV_nxt, errN_nxt);
                  end
               end
               ccs_pkg::CMD_VOUT_VALUE: begin
                  if (vSeq_r == ccs_pkg::SEQ_LOW_SEL) begin
                     vSeq_nxt = ccs_pkg::SEQ_LOW_DONE;
                  end else if (vSeq_r == ccs_pkg::SEQ_HIGH_SEL) begin
                     vSeq_nxt = ccs_pkg::SEQ_IDLE;
                     if (readbackConstBad) begin
                        raiseErr(ccs_pkg::ERR_READBACK, errV_nxt, errN_nxt);
                     end else if (programConstBad) begin
                        raiseErr(ccs_pkg::ERR_PROGRAM, errV_nxt, errN_nxt);
                     end else begin
                        vPend_nxt = 1'b1;
                     end
                  end else begin
                     raiseErr(ccs_pkg::ERR_SEQUENCE, errV_nxt, errN_nxt);
                  end
               end
               ccs_pkg::CMD_IOUT_POINT_SEL, ccs_pkg::CMD_IMON_POINT_SEL: begin
                  if (!constantCurrentRegulation) begin
                     raiseErr(ccs_pkg::ERR_REG_STATE, errV_nxt, errN_nxt);
                  end else if (cmdCode == ccs_pkg::CMD_IMON_POINT_SEL) begin
                     if (HAS_IMON) begin
                        iSeq_nxt = ccs_pkg::SEQ_IMON_SEL;
                     end else begin
                        raiseErr(ccs_pkg::ERR_SEQUENCE, errV_nxt, errN_nxt);
                     end
                  end else if (!argFlag) begin
                     iSeq_nxt = ccs_pkg::SEQ_LOW_SEL;
                  end else if (iSeq_r == ccs_pkg::SEQ_LOW_DONE) begin
                     iSeq_nxt = ccs_pkg::SEQ_HIGH_SEL;
                  end else begin
                     raiseErr(ccs_pkg::ERR_SEQUENCE, errV_nxt, errN_nxt);
                  end
               end
               ccs_pkg::CMD_IOUT_VALUE: begin
                  if (iSeq_r == ccs_pkg::SEQ_LOW_SEL) begin
                     iSeq_nxt = ccs_pkg::SEQ_LOW_DONE;
                  end else if (iSeq_r == ccs_pkg::SEQ_HIGH_SEL ||
                               iSeq_r == ccs_pkg::SEQ_IMON_SEL) begin
                     iSeq_nxt = ccs_pkg::SEQ_IDLE;
                     if (readbackConstBad) begin
                        raiseErr(ccs_pkg::ERR_READBACK, errV_nxt, errN_nxt);
                     end else if (programConstBad) begin
                        raiseErr(ccs_pkg::ERR_PROGRAM, errV_nxt, errN_nxt);
                     end else begin
                        iPend_nxt = 1'b1;
                     end
                  end else begin
                     raiseErr(ccs_pkg::ERR_SEQUENCE, errV_nxt, errN_nxt);
                  end
               end
               ccs_pkg::CMD_OVTRIP_CAL: begin
                  if (!constantVoltageRegulation) begin
                     raiseErr(ccs_pkg::ERR_REG_STATE, errV_nxt, errN_nxt);
                  end else begin
                     busy_nxt    = 1'b1;
                     ovStart_nxt = 1'b1;
                     ovCnt_nxt   = CW'(OVCAL_CYCLES - 1);
                  end
               end
               ccs_pkg::CMD_SAVE: begin
                  comm_nxt  = vPend_r | iPend_r;
                  constWr   = vPend_r | iPend_r;
                  constSel  = {1'b0, iPend_r, vPend_r};
                  vPend_nxt = 1'b0;
                  iPend_nxt = 1'b0;
               end
               default: begin
                  // unknown codes are a sequence fault
                  raiseErr(ccs_pkg::ERR_SEQUENCE, errV_nxt, errN_nxt);
               end
            endcase
         end
      end
   end

   // registers only; mode resets off
   always_ff @(posedge ref_clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         cal_r     <= 1'b0;
         busy_r    <= 1'b0;
         ovCnt_r   <= '0;
         vSeq_r    <= ccs_pkg::SEQ_IDLE;
         iSeq_r    <= ccs_pkg::SEQ_IDLE;
         vPend_r   <= 1'b0;
         iPend_r   <= 1'b0;
         respV_r   <= 1'b0;
         respD_r   <= 2'h0;
         errV_r    <= 1'b0;
         errN_r    <= ccs_pkg::ERR_NONE;
         disc_r    <= 1'b0;
         comm_r    <= 1'b0;
         ovStart_r <= 1'b0;
         ovStore_r <= 1'b0;
      end else begin
         cal_r     <= cal_nxt;
         busy_r    <= busy_nxt;
         ovCnt_r   <= ovCnt_nxt;
         vSeq_r    <= vSeq_nxt;
         iSeq_r    <= iSeq_nxt;
         vPend_r   <= vPend_nxt;
         iPend_r   <= iPend_nxt;
         respV_r   <= respV_nxt;
         respD_r   <= respD_nxt;
         errV_r    <= errV_nxt;
         errN_r    <= errN_nxt;
         disc_r    <= disc_nxt;
         comm_r    <= comm_nxt;
         ovStart_r <= ovStart_nxt;
         ovStore_r <= ovStore_nxt;
      end
   end

   // outputs straight from flops
   assign calEnabled    = cal_r;
   assign busy          = busy_r;
   assign respValid     = respV_r;
   assign respData      = respD_r;
   assign errValid      = errV_r;
   assign errNum        = errN_r;
   assign vConstPending = vPend_r;
   assign iConstPending = iPend_r;
   assign discardPulse  = disc_r;
   assign commitPulse   = comm_r;
   assign ovTripStart   = ovStart_r;
   assign ovTripStore   = ovStore_r;
endmodule // ccs_sequencer
